// [core/afc_flow_ctrl.v]
// Automatic receive flow controller with its configuration register
`timescale 1ns/1ps
`include "afc_regs.vh"
module afc_flow_ctrl #(
  parameter LVL_W = 14
) (
  input wire ref_clk_in, // System clock 50 MHz
  input wire arst_n_in, // Async reset, active low
  input wire reg_wr_in, // Register write strobe
  input wire reg_rd_in, // Register read strobe
  input wire [7:0] reg_addr_in, // Register byte address
  input wire [31:0] reg_wdata_in, // Write data
  output reg [31:0] reg_rdata_out, // Read data
  input wire [LVL_W-1:0] rx_fifo_level_in, // RX data FIFO bytes used
  input wire full_duplex_in, // 1 in full duplex
  input wire speed_100_in, // 1 at 100 Mb/s
  input wire tx_enable_in, // Transmitter enabled
  input wire [15:0] pause_time_value_in, // Pause time from MAC
  input wire rx_frame_start_in, // Pulse: frame preamble seen
  input wire rx_addr_valid_in, // Pulse: destination decoded
  input wire rx_is_group_in, // Multicast destination
  input wire rx_is_all_station_in, // Broadcast destination
  input wire rx_is_own_in, // Own station address
  output reg pause_req_out, // Pulse: send pause frame
  output reg [15:0] pause_time_out, // Pause time of request
  output wire jam_out // Back pressure active
);
  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  reg [31:0] flow_ctrl_config_r;
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flow_ctrl_config_r <= `AFC_CONF_RESET;
    end else if (reg_wr_in && reg_addr_in == `AFC_CONF_OFFSET) begin
      flow_ctrl_config_r <= reg_wdata_in & `AFC_CONF_WMASK;
    end
  end
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (reg_rd_in) begin
      reg_rdata_out <= (reg_addr_in == `AFC_CONF_OFFSET) ? flow_ctrl_config_r : 32'h0000_0000;
    end
  end
  wire [7:0] flow_high_mark = flow_ctrl_config_r[`AFC_HIGH_MSB:`AFC_HIGH_LSB];
  wire [7:0] flow_low_mark = flow_ctrl_config_r[`AFC_LOW_MSB:`AFC_LOW_LSB];
  wire [3:0] jam_duration_sel = flow_ctrl_config_r[`AFC_DUR_MSB:`AFC_DUR_LSB];
  wire jam_on_group_frame = flow_ctrl_config_r[`AFC_BIT_MULT];
  wire jam_on_all_station_frame = flow_ctrl_config_r[`AFC_BIT_BRD];
  wire jam_on_own_address_frame = flow_ctrl_config_r[`AFC_BIT_ADD];
  wire flow_on_every_frame = flow_ctrl_config_r[`AFC_BIT_ANY];
  wire afc_en = |flow_ctrl_config_r[`AFC_CRIT_MSB:0];
  // ----------------------------------------------------------------
  // Level comparison
  // ----------------------------------------------------------------
  // Marks scaled by 64 in a widened compare so large marks never wrap
  wire [LVL_W+7:0] lvl_w = {8'h00, rx_fifo_level_in};
  wire [LVL_W+7:0] hi_bytes = {{LVL_W{1'b0}}, flow_high_mark} << `AFC_UNIT_SHIFT;
  wire [LVL_W+7:0] lo_bytes = {{LVL_W{1'b0}}, flow_low_mark} << `AFC_UNIT_SHIFT;
  wire at_high = lvl_w >= hi_bytes;
  wire below_low = lvl_w < lo_bytes;
  // ----------------------------------------------------------------
  // Full duplex pause control
  // ----------------------------------------------------------------
  // Pause frames need the any-frame bit; low mark below high assumed
  reg paused_r;
  wire fd_ok = full_duplex_in && tx_enable_in && flow_on_every_frame;
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      paused_r <= 1'b0;
      pause_req_out <= 1'b0;
      pause_time_out <= 16'h0000;
    end else begin
      pause_req_out <= 1'b0;
      if (fd_ok && !paused_r && at_high) begin
        paused_r <= 1'b1;
        pause_req_out <= 1'b1;
        pause_time_out <= pause_time_value_in;
      end else if (paused_r && below_low) begin
        paused_r <= 1'b0;
        if (fd_ok && afc_en) begin
          pause_req_out <= 1'b1;
          pause_time_out <= 16'h0000;
        end
      end else if (!full_duplex_in) begin
        paused_r <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // Half duplex back pressure
  // ----------------------------------------------------------------
  wire hd_ok = !full_duplex_in && tx_enable_in && at_high;
  wire crit_hit = (jam_on_group_frame && rx_is_group_in) ||
                  (jam_on_all_station_frame && rx_is_all_station_in) ||
                  (jam_on_own_address_frame && rx_is_own_in);
  // Any-frame mode jams at the preamble without waiting for address decode
  wire start_jam = hd_ok && (flow_on_every_frame ? rx_frame_start_in :
                   (rx_addr_valid_in && crit_hit));
  wire jam_active;
  afc_jam_timer u_timer (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .start_in(start_jam),
    .code_in(jam_duration_sel),
    .speed_100_in(speed_100_in),
    .active_out(jam_active)
  );
  assign jam_out = jam_active && tx_enable_in && !full_duplex_in;
endmodule

// [core/afc_jam_timer.v]
// Back-pressure duration timer counting 100 ns ticks
`timescale 1ns/1ps
`include "afc_regs.vh"
module afc_jam_timer #(
  parameter TICK_CYC = `AFC_TICK_CYC
) (
  input wire ref_clk_in, // System clock
  input wire arst_n_in, // Async reset, active low
  input wire start_in, // Start pulse
  input wire [3:0] code_in, // Duration code
  input wire speed_100_in, // 1 at 100 Mb/s
  output reg active_out // High while jam lasts
);
  // ----------------------------------------------------------------
  // Duration table in 100 ns ticks
  // ----------------------------------------------------------------
  function [12:0] dur_ticks;
    input [3:0] code;
    input fast;
    reg [12:0] base;
    begin
      case (code)
        4'h0: base = 13'd50;
        4'h1: base = 13'd100;
        4'h2: base = 13'd150;
        4'h3: base = 13'd250;
        default: base = 13'd500 * {9'h000, code - 4'h3};
      endcase
      if (code == 4'h4) begin
        base = 13'd500;
      end
      // 10 Mb/s adds 2.2 us
      dur_ticks = fast ? base : base + 13'd22;
    end
  endfunction
  reg [2:0] pre_r;
  reg [12:0] cnt_r;
  wire tick = (pre_r == TICK_CYC[2:0] - 3'h1);
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_r <= 3'h0;
      cnt_r <= 13'h0000;
      active_out <= 1'b0;
    end else if (start_in) begin
      pre_r <= 3'h0;
      cnt_r <= dur_ticks(code_in, speed_100_in);
      active_out <= 1'b1;
    end else if (active_out) begin
      pre_r <= tick ? 3'h0 : pre_r + 3'h1;
      if (tick) begin
        cnt_r <= cnt_r - 13'h0001;
        if (cnt_r == 13'h0001) begin
          active_out <= 1'b0;
        end
      end
    end
  end
endmodule

// [core/afc_regs.vh]
// Register offsets, field positions, reset values and timing constants of the flow controller
`ifndef AFC_REGS_VH
`define AFC_REGS_VH
// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define AFC_CONF_OFFSET 8'hac
`define AFC_CONF_RESET 32'h0000_0000
`define AFC_CONF_WMASK 32'h00ff_ffff
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AFC_HIGH_MSB 23
`define AFC_HIGH_LSB 16
`define AFC_LOW_MSB 15
`define AFC_LOW_LSB 8
`define AFC_DUR_MSB 7
`define AFC_DUR_LSB 4
`define AFC_BIT_MULT 3
`define AFC_BIT_BRD 2
`define AFC_BIT_ADD 1
`define AFC_BIT_ANY 0
`define AFC_CRIT_MSB 3
`define AFC_UNIT_SHIFT 6
// ----------------------------------------------------------------
// Timing: one tick per 100 ns
// ----------------------------------------------------------------
`define AFC_CLK_MHZ 50
`define AFC_TICK_NS 100
`define AFC_CLK_NS 20
`define AFC_TICK_CYC (`AFC_TICK_NS / `AFC_CLK_NS)
`endif

// [tb/afc_flow_ctrl_asserts.sv]
// Port-level assertions for the automatic flow controller
`timescale 1ns/1ps
module afc_flow_ctrl_asserts #(parameter LVL_W = 14) (
  input wire ref_clk_in, input wire arst_n_in, input wire reg_wr_in,
  input wire [7:0] reg_addr_in, input wire [31:0] reg_wdata_in,
  input wire [LVL_W-1:0] rx_fifo_level_in, input wire full_duplex_in,
  input wire tx_enable_in, input wire [15:0] pause_time_value_in,
  input wire rx_frame_start_in, input wire rx_addr_valid_in,
  input wire pause_req_out, input wire [15:0] pause_time_out, input wire jam_out
);
  logic [31:0] cfg_r;
  logic sent_r;
  wire hi = rx_fifo_level_in >= {cfg_r[23:16], 6'h0};
  wire lo = rx_fifo_level_in < {cfg_r[15:8], 6'h0};
  wire arm = full_duplex_in && tx_enable_in && cfg_r[0];
  // Shadow of the config and of the pending high-mark pause
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_r <= 32'h0;
      sent_r <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'hac) cfg_r <= reg_wdata_in;
      if (!full_duplex_in) sent_r <= 1'b0;
      else if (pause_req_out) sent_r <= pause_time_out != 16'h0;
    end
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  a_jam_tx_off: assert property (!tx_enable_in |-> !jam_out)
    else $error("jam while transmitter off");
  a_jam_full_dup: assert property (full_duplex_in |-> !jam_out)
    else $error("jam in full duplex");
  a_pause_tx_off: assert property (!$past(tx_enable_in) |-> !pause_req_out)
    else $error("pause while transmitter off");
  a_pause_pulse: assert property (pause_req_out |=> !pause_req_out)
    else $error("pause request longer than one cycle");
  a_pause_any: assert property (pause_req_out |-> $past(cfg_r[0]) && $past(full_duplex_in))
    else $error("pause without any-frame enable");
  a_hi_pause: assert property (arm && hi && !sent_r && !pause_req_out |=>
    pause_req_out && pause_time_out == $past(pause_time_value_in)) else $error("no high pause");
  a_zero_pause: assert property (arm && lo && sent_r && !pause_req_out |=>
    pause_req_out && pause_time_out == 16'h0) else $error("no zero pause");
  a_zero_sent: assert property (pause_req_out && pause_time_out == 16'h0 |-> sent_r)
    else $error("zero pause without earlier pause");
  a_jam_cause: assert property ($rose(jam_out) && $stable(tx_enable_in) &&
    $stable(full_duplex_in) |-> $past(rx_addr_valid_in) || $past(rx_frame_start_in))
    else $error("jam without incoming frame");
endmodule

// [tb/afc_flow_ctrl_tb.sv]
// Self-checking bench for the automatic flow controller
`timescale 1ns/1ps
module afc_flow_ctrl_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, fd = 1, spd = 1, txen = 1, send = 0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0, rdat;
  logic [13:0] lvl = 14'h0;
  logic [1:0] kind = 2'h0;
  logic fs, av, ig, ia, io, preq, jam;
  logic [15:0] ptime;
  int n_fail = 0, n_compared = 0, cyc = 0;
  afc_flow_ctrl dut (.ref_clk_in(clk), .arst_n_in(rst_n), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdat), .rx_fifo_level_in(lvl),
    .full_duplex_in(fd), .speed_100_in(spd), .tx_enable_in(txen), .pause_time_value_in(16'h1234),
    .rx_frame_start_in(fs), .rx_addr_valid_in(av), .rx_is_group_in(ig),
    .rx_is_all_station_in(ia), .rx_is_own_in(io), .pause_req_out(preq),
    .pause_time_out(ptime), .jam_out(jam));
  afc_link_partner peer (.ref_clk_in(clk), .send_in(send), .kind_in(kind),
    .frame_start_out(fs), .addr_valid_out(av), .is_group_out(ig), .is_all_out(ia),
    .is_own_out(io));
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cyc == 10000) begin n_fail++; tally_and_finish; end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin n_fail++; $display("[FAIL] %s expected %h seen %h", w, e, g); end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk); addr = a; wdata = d; wr = 1; @(negedge clk); wr = 0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk); addr = a; rd = 1; @(negedge clk); rd = 0; d = rdat;
  endtask
  task automatic pause_seen(input logic [15:0] t);
    for (int i = 0; i < 8 && preq !== 1'b1; i++) @(negedge clk);
    chk("pause_req", 1, preq); chk("pause_time", t, ptime);
    @(negedge clk); chk("pause width", 0, preq);
  endtask
  task automatic quiet(input int n);
    int k = 0;
    repeat (n) begin @(negedge clk); k += preq; end
    chk("stray pauses", 0, k);
  endtask
  task automatic t_regs;
    logic [31:0] d;
    rreg(8'hac, d); chk("cfg reset", 0, d);
    wreg(8'hac, 32'hffff_ffff); wreg(8'ha8, 32'h0); rreg(8'hac, d);
    chk("cfg rw", 32'h00ff_ffff, d);
    rreg(8'ha8, d); chk("unmapped", 0, d);
  endtask
  task automatic t_pause;
    wreg(8'hac, 32'h0002_0101); lvl = 127; quiet(10);
    lvl = 128; pause_seen(16'h1234); quiet(10);
    lvl = 64; quiet(5);
    lvl = 63; pause_seen(16'h0); quiet(5);
    txen = 0; lvl = 200; quiet(10);
    wreg(8'hac, 32'h0002_010e); txen = 1; quiet(10);
  endtask
  task automatic t_jam;
    logic [7:0] c [8] = '{8'h02, 8'h04, 8'h08, 8'h01, 8'h08, 8'h12, 8'h02, 8'h02};
    logic [1:0] kd [8] = '{0, 1, 2, 3, 0, 0, 0, 0};
    int len [8] = '{250, 250, 250, 250, 0, 500, 360, 0};
    int n;
    fd = 0; lvl = 100;
    for (int i = 0; i < 8; i++) begin
      spd = i != 6; txen = i != 7;
      wreg(8'hac, {16'h0100, c[i]});
      kind = kd[i]; send = 1; @(negedge clk); send = 0;
      for (int k = 0; k < 6 && jam !== 1'b1; k++) @(negedge clk);
      for (n = 0; jam === 1'b1 && n < 700; n++) @(negedge clk);
      chk("jam cycles", len[i], n);
    end
  endtask
  task tally_and_finish;
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    t_regs; t_pause; t_jam;
    tally_and_finish;
  end
endmodule
bind afc_flow_ctrl afc_flow_ctrl_asserts #(.LVL_W(LVL_W)) u_chk (.*);

// [tb/afc_link_partner.sv]
// Remote station model delivering received frames
`timescale 1ns/1ps
module afc_link_partner (
  input wire ref_clk_in, // System clock
  input wire send_in, // Start one frame
  input wire [1:0] kind_in, // 0 own, 1 broadcast, 2 multicast, 3 other
  output reg frame_start_out = 1'b0, output reg addr_valid_out = 1'b0,
  output reg is_group_out = 1'b0, output reg is_all_out = 1'b0, output reg is_own_out = 1'b0
);
  always @(posedge ref_clk_in) begin
    frame_start_out <= send_in;
    addr_valid_out <= frame_start_out;
    // Type lines mean nothing outside the decode pulse, so they churn there
    if (frame_start_out) {is_group_out, is_all_out, is_own_out} <= 3'h1 << kind_in;
    else {is_group_out, is_all_out, is_own_out} <= ~{is_group_out, is_all_out, is_own_out};
  end
endmodule
